// >>> etpc_pkg.sv
// Constants and types shared by the eight-bit timer, PWM and event counter.
// Function
// RQ1: Enable bit low stops, high runs counter.
// RQ2: Eight-bit up counter, one step per tick.
// RQ3: Wrap FF to 00 sets sticky overflow flag.
// RQ4: Overflow reloads counter from reload value.
// RQ5: Reload always active while timer runs.
// RQ6: Reload double buffered, new value after overflow.
// RQ7: Enabled overflow requests interrupt at vector 000E.
// RQ8: Green mode keeps running, never wakes system.
// RQ9: Internal select: instruction clock or oscillator.
// RQ10: External select counts pin, ignores prescaler.
// RQ11: Prescaler field divides by 128 down to 1.
// RQ12: Pin enable switches pin from GPIO to PWM.
// RQ13: Single pulse: one pulse, flag, clear enable.
// RQ14: Software configures mode before enabling timer.
// RQ15: Software writes counter equal reload before start.
// RQ16: Software clears overflow flag in service routine.
// RQ17: Event mode counts falling edges of pin.
// RQ18: PWM high at period start, low at duty.
// RQ19: Duty not above reload keeps PWM low.
// RQ20: Event pin synchronised before edge detection.
package etpc_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] ETPC_MODE_OFS   = 8'hBC;
   localparam logic [7:0] ETPC_COUNT_OFS  = 8'hBD;
   localparam logic [7:0] ETPC_STATUS_OFS = 8'hC0;

   localparam logic [7:0] ETPC_MODE_RST   = 8'h00;
   localparam logic [7:0] ETPC_COUNT_RST  = 8'h00;
   localparam logic [7:0] ETPC_RELOAD_RST = 8'h00;

   // Status register bit positions.
   localparam int ETPC_FLAG_BIT = 0;
   localparam int ETPC_IEN_BIT  = 1;

   // ***************************************************************
   // Counter and prescaler constants
   // ***************************************************************
   localparam logic [7:0]  ETPC_COUNT_FULL = 8'hFF;
   localparam logic [6:0]  ETPC_PRE_MASK   = 7'h7F;
   localparam logic [6:0]  ETPC_PRE_RST    = 7'h00;
   localparam logic [15:0] ETPC_IRQ_VECTOR = 16'h000E;

   // ***************************************************************
   // Mode register layout, bit 7 down to bit 0
   // ***************************************************************
   typedef struct packed {
      logic       timer_run_enable;
      logic [2:0] clock_divider_select;
      logic       external_event_select;
      logic       internal_clock_select;
      logic       single_pulse_mode;
      logic       pwm_pin_enable;
   } etpc_mode_t;

endpackage

// >>> etpc_top.sv
// Eight-bit auto-reload timer with prescaler, event counter and PWM output.
`timescale 1ns/10ps

module etpc_top
   import etpc_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic       CLOCK_I,
   input  wire logic       RST_B_I,
   input  wire logic [7:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [7:0] RDATA_O,
   input  wire logic       FCPU_TICK_I,
   input  wire logic       FHOSC_TICK_I,
   input  wire logic       EVENT_PIN_I,
   input  wire logic [7:0] RELOAD_VALUE_I,
   input  wire logic [7:0] DUTY_VALUE_I,
   input  wire logic       GREEN_MODE_I,
   output logic            PWM_O,
   output logic            PWM_PIN_SEL_O,
   output logic            IRQ_O,
   output logic      [15:0] IRQ_VECTOR_O,
   output logic            WAKEUP_O
);

   // ***************************************************************
   // Elaboration check
   // ***************************************************************
   generate
      if (CNT_W != 8) begin : g_bad_width
         $error("etpc_top supports only an eight-bit counter");
      end
      // The read decoder would alias two registers onto one address.
      if ((ETPC_MODE_OFS == ETPC_COUNT_OFS) || (ETPC_MODE_OFS == ETPC_STATUS_OFS) ||
          (ETPC_COUNT_OFS == ETPC_STATUS_OFS)) begin : g_bad_map
         $error("etpc_top register offsets must differ");
      end
      // The status byte holds both bits; they must not overlap.
      if ((ETPC_FLAG_BIT == ETPC_IEN_BIT) || (ETPC_FLAG_BIT > 7) ||
          (ETPC_IEN_BIT > 7)) begin : g_bad_bits
         $error("etpc_top status bit positions are invalid");
      end
   endgenerate

   // ***************************************************************
   // State
   // ***************************************************************
   etpc_mode_t mode;
   logic [7:0] count;
   logic [7:0] reload_active;
   logic       overflow_flag;
   logic       overflow_interrupt_enable;
   logic [6:0] prescale;
   logic       ev_s1;
   logic       ev_s2;
   logic       ev_s3;
   logic       ev_level;
   logic       pwm_level;
   logic       pwm_out;
   logic       pin_sel;
   logic       irq;

   logic       wr_mode;
   logic       wr_count;
   logic       wr_status;
   logic       src_tick;
   logic [6:0] pre_mask;
   logic       int_tick;
   logic       ev_fall;
   logic       step;
   logic       overflow;
   logic       duty_ok;
   logic       next_duty_ok;
   logic [6:0] next_prescale;
   logic       next_ev_level;
   logic [7:0] next_count;
   logic [7:0] next_reload_active;
   etpc_mode_t next_mode;
   logic       next_flag;
   logic       next_ien;
   logic       next_pwm_level;
   logic [7:0] next_rdata;

   assign wr_mode   = WR_I && (ADDR_I == ETPC_MODE_OFS);
   assign wr_count  = WR_I && (ADDR_I == ETPC_COUNT_OFS);
   assign wr_status = WR_I && (ADDR_I == ETPC_STATUS_OFS);

   // ***************************************************************
   // Clock source and prescaler
   // ***************************************************************
   // The oscillator tick goes through the same prescaler as the
   // instruction tick, since both table rows list all eight divisors.
   assign src_tick = mode.internal_clock_select ? FHOSC_TICK_I // RQ9
                                                : FCPU_TICK_I;

   // Field value 0 keeps all seven bits in the mask (divide by 128),
   // value 7 keeps none (divide by 1).
   assign pre_mask = ETPC_PRE_MASK >> mode.clock_divider_select; // RQ11

   assign int_tick = src_tick && ((prescale & pre_mask) == pre_mask);

   // Clearing the prescaler while stopped makes the first period after an
   // enable a full one, at the cost of losing any partial division.
   always_comb begin
      next_prescale = prescale;
      if (!mode.timer_run_enable || mode.external_event_select) begin
         next_prescale = ETPC_PRE_RST; // RQ10
      end else if (src_tick) begin
         next_prescale = prescale + 7'h01;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         prescale <= ETPC_PRE_RST;
      end else begin
         prescale <= next_prescale;
      end
   end

   // ***************************************************************
   // Event pin synchroniser and falling edge detector
   // ***************************************************************
   // The first stage feeds only the second. A level change is accepted
   // once the second and third stages agree, which rejects one-cycle
   // glitches caught at the metastable stage.
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ev_s1 <= 1'b1;
         ev_s2 <= 1'b1;
         ev_s3 <= 1'b1;
      end else begin
         ev_s1 <= EVENT_PIN_I; // RQ20
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
      end
   end

   always_comb begin
      next_ev_level = ev_level;
      if (ev_s2 == ev_s3) begin
         next_ev_level = ev_s3; // RQ20
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ev_level <= 1'b1;
      end else begin
         ev_level <= next_ev_level;
      end
   end

   assign ev_fall = ev_level && !ev_s3 && !ev_s2; // RQ17

   // ***************************************************************
   // Counter
   // ***************************************************************
   assign step = mode.timer_run_enable && // RQ1
                 (mode.external_event_select ? ev_fall : int_tick); // RQ10

   assign overflow = step && (count == ETPC_COUNT_FULL); // RQ3

   // A software write to the counter wins over a count step in the
   // same cycle, so a freshly written start value is never skipped.
   always_comb begin
      next_count = count;
      if (wr_count) begin
         next_count = WDATA_I;
      end else if (overflow) begin
         next_count = RELOAD_VALUE_I; // RQ4 RQ5
      end else if (step) begin
         next_count = count + 8'h01; // RQ2
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         count <= ETPC_COUNT_RST;
      end else begin
         count <= next_count;
      end
   end

   // The reload input is the buffer software writes. Its value moves
   // into the working copy only at overflow, or while the timer is
   // stopped, so a mid-period change cannot disturb the period.
   always_comb begin
      next_reload_active = reload_active;
      if (overflow || !mode.timer_run_enable) begin
         next_reload_active = RELOAD_VALUE_I; // RQ6
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         reload_active <= ETPC_RELOAD_RST;
      end else begin
         reload_active <= next_reload_active;
      end
   end

   // ***************************************************************
   // Mode register
   // ***************************************************************
   // A software write in the same cycle as the hardware clear wins, so a
   // request for the next pulse is never lost.
   always_comb begin
      next_mode = mode;
      if (wr_mode) begin
         next_mode = etpc_mode_t'(WDATA_I);
      end else if (overflow && mode.single_pulse_mode && mode.pwm_pin_enable) begin
         next_mode.pwm_pin_enable = 1'b0; // RQ13
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         mode <= etpc_mode_t'(ETPC_MODE_RST);
      end else begin
         mode <= next_mode;
      end
   end

   // ***************************************************************
   // Overflow flag and interrupt enable
   // ***************************************************************
   // Writing 0 to the flag bit clears it; an overflow in the same
   // cycle wins, so no event is lost.
   always_comb begin
      next_flag = overflow_flag;
      if (overflow) begin
         next_flag = 1'b1; // RQ3 RQ13
      end else if (wr_status && !WDATA_I[ETPC_FLAG_BIT]) begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         overflow_flag <= 1'b0;
      end else begin
         overflow_flag <= next_flag;
      end
   end

   always_comb begin
      next_ien = overflow_interrupt_enable;
      if (wr_status) begin
         next_ien = WDATA_I[ETPC_IEN_BIT];
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         overflow_interrupt_enable <= 1'b0;
      end else begin
         overflow_interrupt_enable <= next_ien;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         irq <= 1'b0;
      end else begin
         irq <= overflow_flag && overflow_interrupt_enable; // RQ7
      end
   end

   assign IRQ_O        = irq;
   assign IRQ_VECTOR_O = ETPC_IRQ_VECTOR; // RQ7

   // Green mode never raises system wake-up, which is tied low; the timer ignores it and
   // keeps counting, flagging and driving PWM.
   assign WAKEUP_O = 1'b0 & GREEN_MODE_I; // RQ8

   // ***************************************************************
   // PWM
   // ***************************************************************
   assign duty_ok      = DUTY_VALUE_I > reload_active; // RQ19
   assign next_duty_ok = DUTY_VALUE_I > RELOAD_VALUE_I;

   always_comb begin
      next_pwm_level = pwm_level;
      if (!mode.timer_run_enable) begin
         next_pwm_level = duty_ok; // RQ18
      end else if (overflow) begin
         next_pwm_level = next_duty_ok; // RQ18 RQ19
      end else if (!duty_ok || (count == DUTY_VALUE_I)) begin
         next_pwm_level = 1'b0; // RQ18 RQ19
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pwm_level <= 1'b0;
      end else begin
         pwm_level <= next_pwm_level;
      end
   end

   // The waveform reaches the pin only while the timer runs and the pin
   // is handed to PWM; a stopped timer holds it low, and it belongs to GPIO only while pin enable is clear.
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pwm_out <= 1'b0;
         pin_sel <= 1'b0;
      end else begin
         pwm_out <= mode.pwm_pin_enable && mode.timer_run_enable && pwm_level; // RQ12
         pin_sel <= mode.pwm_pin_enable; // RQ12
      end
   end

   assign PWM_O         = pwm_out;
   assign PWM_PIN_SEL_O = pin_sel;

   // ***************************************************************
   // Register read port
   // ***************************************************************
   // Read data is zero outside the read slot, so several blocks may share
   // one OR-combined return bus without a multiplexer.
   always_comb begin
      next_rdata = 8'h00;
      if (RD_I) begin
         unique case (ADDR_I)
            ETPC_MODE_OFS:   next_rdata = mode;
            ETPC_COUNT_OFS:  next_rdata = count;
            ETPC_STATUS_OFS: next_rdata = {6'h00, overflow_interrupt_enable, overflow_flag};
            default:         next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         RDATA_O <= 8'h00;
      end else begin
         RDATA_O <= next_rdata;
      end
   end

endmodule // etpc_top

// >>> etpc_top_checker.sv
// Port-level assertions for the timer block.
`timescale 1ns/10ps
module etpc_top_checker
   import etpc_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic        CLOCK_I,
   input wire logic        RST_B_I,
   input wire logic [7:0]  ADDR_I,
   input wire logic [7:0]  WDATA_I,
   input wire logic        WR_I,
   input wire logic        RD_I,
   input wire logic [7:0]  RDATA_O,
   input wire logic        PWM_PIN_SEL_O,
   input wire logic        IRQ_O,
   input wire logic [15:0] IRQ_VECTOR_O,
   input wire logic        WAKEUP_O
);
   // ***********************************
   // Properties
   // ***********************************
   default clocking @(posedge CLOCK_I);
   endclocking
   default disable iff (!RST_B_I);

   logic st_rd;
   logic md_wr;
   assign st_rd = RD_I && ADDR_I == ETPC_STATUS_OFS;
   assign md_wr = WR_I && ADDR_I == ETPC_MODE_OFS;

   vec_const_a: assert property (IRQ_VECTOR_O == ETPC_IRQ_VECTOR)
      else $error("interrupt vector wrong");
   no_wake_a: assert property (WAKEUP_O == 1'b0)
      else $error("wake-up raised");
   rd_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
      else $error("read data outside read slot");
   sel_copy_a: assert property (md_wr ##1 !WR_I |=> PWM_PIN_SEL_O == $past(WDATA_I[0], 2))
      else $error("pin select does not follow mode");
   irq_hold_a: assert property (IRQ_O && !WR_I && !$past(WR_I) |=> IRQ_O)
      else $error("interrupt dropped without a write");
   irq_match_a: assert property (st_rd |=> IRQ_O == (RDATA_O[0] & RDATA_O[1]))
      else $error("interrupt differs from flag and enable");
   irq_off_a: assert property (WR_I && ADDR_I == ETPC_STATUS_OFS && !WDATA_I[1] |=> ##1 !IRQ_O)
      else $error("interrupt while disabled");
   rd_mode_a: assert property (md_wr ##1 RD_I && ADDR_I == ETPC_MODE_OFS |=> RDATA_O == $past(WDATA_I, 2))
      else $error("mode readback wrong");

   cover property (IRQ_O);
   cover property (PWM_PIN_SEL_O ##1 !PWM_PIN_SEL_O);
   cover property (st_rd);
endmodule // etpc_top_checker

bind etpc_top etpc_top_checker #(.CNT_W(CNT_W)) etpc_top_checker_i (
   .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PWM_PIN_SEL_O(PWM_PIN_SEL_O),
   .IRQ_O(IRQ_O), .IRQ_VECTOR_O(IRQ_VECTOR_O), .WAKEUP_O(WAKEUP_O));

// >>> etpc_env_model.sv
// Far-side model: clock-enable ticks and an external event source.
`timescale 1ns/10ps
module etpc_env_model (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic ev_en_i,
   output logic      fcpu_tick_o,
   output logic      fhosc_tick_o,
   output logic      ev_pin_o
);
   logic [2:0] ev_cnt;
   // Instruction ticks run at half rate so the two sources can be told apart.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fcpu_tick_o <= 1'b0;
         ev_cnt      <= 3'h0;
      end else begin
         fcpu_tick_o <= !fcpu_tick_o;
         ev_cnt      <= ev_en_i ? ev_cnt + 3'h1 : 3'h0;
      end
   end
   assign fhosc_tick_o = 1'b1;
   // Idle high, one falling edge every eight cycles while enabled.
   assign ev_pin_o = !(ev_en_i && ev_cnt[2]);
endmodule // etpc_env_model

// >>> etpc_top_tb.sv
// Self-checking bench for the timer block.
`timescale 1ns/10ps
module etpc_top_tb;
   import etpc_pkg::*;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        wr = 1'b0, rd = 1'b0, green = 1'b0, ev_en = 1'b0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, reload = 8'h00, duty = 8'h00;
   logic [7:0]  rdata;
   logic        fcpu, fhosc, ev_pin, pwm, pwm_sel, irq, wake;
   logic [15:0] vec;
   int          n_errors = 0, checked = 0, cyc = 0, k;

   always #4 clock = !clock;

   etpc_env_model etpc_env_model_i (.clk_i(clock), .rst_b_i(rst_b), .ev_en_i(ev_en),
      .fcpu_tick_o(fcpu), .fhosc_tick_o(fhosc), .ev_pin_o(ev_pin));
   etpc_top etpc_top_i (.CLOCK_I(clock), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FCPU_TICK_I(fcpu), .FHOSC_TICK_I(fhosc),
      .EVENT_PIN_I(ev_pin), .RELOAD_VALUE_I(reload), .DUTY_VALUE_I(duty),
      .GREEN_MODE_I(green), .PWM_O(pwm), .PWM_PIN_SEL_O(pwm_sel), .IRQ_O(irq),
      .IRQ_VECTOR_O(vec), .WAKEUP_O(wake));

   task chk8(input logic [7:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task reg_wr(input logic [7:0] a, d);
      // A write straight after a write lets one edge pass first, so the
      // strobe is never lowered and raised again in the same time step.
      if (wr) @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task reg_rd(input logic [7:0] a, e);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      chk8(rdata, e);
   endtask
   task final_report;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Software keeps counter equal to reload at start, then moves reload mid-period.
   task ovf(input logic [7:0] m, c, d, em, input logic pw);
      int n;
      duty <= d;
      reload <= c;
      green <= 1'b1;
      reg_wr(ETPC_STATUS_OFS, 8'h02);
      reg_wr(ETPC_COUNT_OFS, c);
      reg_wr(ETPC_MODE_OFS, m);
      reload <= 8'h80;
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      chk1(irq, 1'b1);
      chk1(wake, 1'b0);
      chk8(vec[7:0], ETPC_IRQ_VECTOR[7:0]);
      chk8(vec[15:8], ETPC_IRQ_VECTOR[15:8]);
      if (em[0]) chk1(pwm, pw);
      reg_rd(ETPC_MODE_OFS, em);
      chk1(pwm_sel, em[0]);
      reg_wr(ETPC_MODE_OFS, 8'h00);
      reg_rd(ETPC_COUNT_OFS, 8'h80);
      reg_rd(ETPC_STATUS_OFS, 8'h03);
      reg_wr(ETPC_STATUS_OFS, 8'h00);
      $display("overflow test done, mode %h", m);
   endtask

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         final_report;
      end
   end

   // ***********************************
   // Test sequence
   // ***********************************
   initial begin
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      reg_rd(ETPC_MODE_OFS, ETPC_MODE_RST);
      reg_rd(ETPC_COUNT_OFS, ETPC_COUNT_RST);
      reg_rd(ETPC_STATUS_OFS, 8'h00);
      reg_rd(8'h10, 8'h00);
      reg_wr(ETPC_MODE_OFS, 8'h72);
      reg_rd(ETPC_MODE_OFS, 8'h72);
      reg_wr(ETPC_COUNT_OFS, 8'h40);
      repeat (20) @(posedge clock);
      reg_rd(ETPC_COUNT_OFS, 8'h40);
      $display("register test done");
      for (k = 0; k < 8; k++) begin
         reg_wr(ETPC_COUNT_OFS, 8'h10);
         reg_wr(ETPC_MODE_OFS, {1'b1, k[2:0], 4'h4});
         repeat (3 * (1 << (7 - k)) + (1 << (7 - k)) / 2 - 1) @(posedge clock);
         reg_wr(ETPC_MODE_OFS, {1'b0, k[2:0], 4'h4});
         reg_rd(ETPC_COUNT_OFS, 8'h13);
      end
      $display("prescaler test done");
      reg_wr(ETPC_COUNT_OFS, 8'h10);
      reg_wr(ETPC_MODE_OFS, 8'hF0);
      repeat (7) @(posedge clock);
      reg_wr(ETPC_MODE_OFS, 8'h70);
      reg_rd(ETPC_COUNT_OFS, 8'h14);
      $display("clock source test done");
      green <= 1'b1;
      reg_wr(ETPC_COUNT_OFS, 8'h10);
      reg_wr(ETPC_MODE_OFS, 8'h08);
      reg_wr(ETPC_MODE_OFS, 8'h88);
      ev_en <= 1'b1;
      repeat (40) @(posedge clock);
      ev_en <= 1'b0;
      repeat (8) @(posedge clock);
      reg_wr(ETPC_MODE_OFS, 8'h08);
      reg_rd(ETPC_COUNT_OFS, 8'h15);
      $display("event test done");
      ovf(8'h85, 8'hFD, 8'hFE, 8'h85, 1'b1);
      ovf(8'h87, 8'hFE, 8'hFE, 8'h86, 1'b0);
      ovf(8'h85, 8'hFE, 8'h40, 8'h85, 1'b0);
      final_report;
   end
endmodule // etpc_top_tb
